/* File: design/nstx_exec.sv */
// Function
// [RULE1] nibble swap of file reg, result to w (d=0) or file (d=1), no flags
// [RULE2] high table read loads w with upper rom word byte, two cycles, no flags
// [RULE3] low table read loads w with lower rom word byte, two cycles, no flags
// [RULE4] table pointer is page register upper bits with indirect register low byte
// [RULE5] zero test sets zero flag when file register is zero, no write
// [RULE6] xor literal writes w xor k into w, updates zero flag only
// [RULE7] xor file computes w xor f, to w or file per d, updates zero flag
// [RULE8] zero test clears zero flag when file register is nonzero
`timescale 1ns/1ns
module nstx_exec (
    input  wire logic                                ref_clk,
    input  wire logic                                rst_n,
    input  wire logic                                instr_valid,
    input  wire logic [13:0]                         instr,
    input  wire logic [7:0]                          file_rdata,
    input  wire logic [nstx_pkg::NSTX_PAGE_W-1:0]    table_page_register,
    input  wire logic [7:0]                          indirect_address_register,
    input  wire logic [13:0]                         rom_rdata,
    output logic                                     busy,
    output logic [nstx_pkg::NSTX_ADDR_W-1:0]         file_addr,
    output logic                                     file_we,
    output logic [7:0]                               file_wdata,
    output logic [nstx_pkg::NSTX_PC_W-1:0]           table_pointer,
    output logic                                     rom_re,
    output logic [7:0]                               w_reg,
    output logic                                     zero_flag
);
    // file_rdata is combinational from file_addr output (same clock)
    nstx_pkg::nstx_state_t state_q, state_d;
    logic        we_q, we_d, re_q, re_d, hi_q, hi_d, z_q, z_d, busy_q, busy_d;
    logic [7:0]  wd_q, wd_d, w_q, w_d;
    logic [nstx_pkg::NSTX_PC_W-1:0] tp_q, tp_d;

    function automatic logic match(input logic [13:0] op, input logic [13:0] mask,
                                   input logic [13:0] pat);
        return (op & mask) == pat;
    endfunction

    logic dest_file;
    logic [7:0] swapped, xored, xlit;
    assign dest_file = instr[nstx_pkg::NSTX_DEST_BIT];
    assign swapped   = {file_rdata[3:0], file_rdata[7:4]};
    assign xored     = w_q ^ file_rdata;
    // one xor feeds both w and the zero flag
    assign xlit      = w_q ^ instr[7:0];

    always_comb begin
        state_d = state_q;
        we_d    = 1'b0;
        wd_d    = wd_q;
        w_d     = w_q;
        z_d     = z_q;
        re_d    = 1'b0;
        hi_d    = hi_q;
        busy_d  = 1'b0;
        tp_d    = {table_page_register, indirect_address_register}; // RULE4
        case (state_q)
            nstx_pkg::NSTX_IDLE: begin
                if (instr_valid) begin
                    if (match(instr, nstx_pkg::NSTX_OP_SWAP_MASK, nstx_pkg::NSTX_OP_SWAP)) begin
                        if (dest_file) begin // RULE1
                            we_d = 1'b1;
                            wd_d = swapped;
                        end else begin
                            w_d = swapped;
                        end
                    end else if (match(instr, nstx_pkg::NSTX_OP_SWAP_MASK,
                                       nstx_pkg::NSTX_OP_XORF)) begin
                        z_d = (xored == 8'h00); // RULE7
                        if (dest_file) begin
                            we_d = 1'b1;
                            wd_d = xored;
                        end else begin
                            w_d = xored;
                        end
                    end else if (match(instr, nstx_pkg::NSTX_OP_ZTEST_MASK,
                                       nstx_pkg::NSTX_OP_ZTEST)) begin
                        z_d = (file_rdata == 8'h00); // RULE5 RULE8
                    end else if (match(instr, nstx_pkg::NSTX_OP_SWAP_MASK,
                                       nstx_pkg::NSTX_OP_XORL)) begin
                        w_d = xlit; // RULE6
                        z_d = (xlit == 8'h00);
                    end else if (instr == nstx_pkg::NSTX_OP_TABH
                                 || instr == nstx_pkg::NSTX_OP_TABL) begin
                        // second cycle reads rom; pointer sampled now
                        hi_d    = (instr == nstx_pkg::NSTX_OP_TABH);
                        re_d    = 1'b1;
                        busy_d  = 1'b1;
                        state_d = nstx_pkg::NSTX_TAB_FETCH;
                    end
                end
            end
            nstx_pkg::NSTX_TAB_FETCH: begin
                tp_d    = tp_q;
                // upper byte holds the six high bits of the 14-bit word
                w_d     = hi_q ? {2'b00, rom_rdata[13:8]} : rom_rdata[7:0]; // RULE2 RULE3
                state_d = nstx_pkg::NSTX_IDLE;
            end
            default: state_d = nstx_pkg::NSTX_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q <= nstx_pkg::NSTX_IDLE;
            we_q    <= 1'b0;
            wd_q    <= 8'h00;
            w_q     <= nstx_pkg::NSTX_W_RESET;
            z_q     <= 1'b0;
            re_q    <= 1'b0;
            hi_q    <= 1'b0;
            busy_q  <= 1'b0;
            tp_q    <= '0;
        end else begin
            state_q <= state_d;
            we_q    <= we_d;
            wd_q    <= wd_d;
            w_q     <= w_d;
            z_q     <= z_d;
            re_q    <= re_d;
            hi_q    <= hi_d;
            busy_q  <= busy_d;
            tp_q    <= tp_d;
        end
    end

    // file address mirrors instruction low bits combinationally for same-cycle reads
    assign file_addr     = instr[nstx_pkg::NSTX_ADDR_W-1:0];
    assign file_we       = we_q;
    assign file_wdata    = wd_q;
    assign table_pointer = tp_q;
    assign rom_re        = re_q;
    assign w_reg         = w_q;
    assign zero_flag     = z_q;
    assign busy          = busy_q;

    chk_swap_to_w: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE1
        (state_q == nstx_pkg::NSTX_IDLE && instr_valid
         && match(instr, nstx_pkg::NSTX_OP_SWAP_MASK, nstx_pkg::NSTX_OP_SWAP) && !dest_file)
        |=> (w_reg == $past(swapped)) && $stable(zero_flag) && !file_we)
        else $error("swap to w wrong");
    chk_swap_to_file: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE1
        (state_q == nstx_pkg::NSTX_IDLE && instr_valid
         && match(instr, nstx_pkg::NSTX_OP_SWAP_MASK, nstx_pkg::NSTX_OP_SWAP) && dest_file)
        |=> file_we && file_wdata == $past(swapped) && $stable(w_reg))
        else $error("swap to file wrong");
    sequence tab_start(logic h);
        state_q == nstx_pkg::NSTX_IDLE && instr_valid
        && instr == (h ? nstx_pkg::NSTX_OP_TABH : nstx_pkg::NSTX_OP_TABL);
    endsequence
    chk_tab_high: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE2
        tab_start(1'b1) |=> busy ##1 (w_reg == {2'b00, $past(rom_rdata[13:8])})
        && $stable(zero_flag))
        else $error("table high read wrong");
    chk_tab_low: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE3
        tab_start(1'b0) |=> busy ##1 (w_reg == $past(rom_rdata[7:0]) && !busy))
        else $error("table low read wrong");
    chk_tab_pointer: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE4
        tab_start(1'b0) or tab_start(1'b1)
        |=> table_pointer == $past({table_page_register, indirect_address_register}))
        else $error("table pointer wrong");
    chk_ztest_set: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE5
        (state_q == nstx_pkg::NSTX_IDLE && instr_valid && file_rdata == 8'h00
         && match(instr, nstx_pkg::NSTX_OP_ZTEST_MASK, nstx_pkg::NSTX_OP_ZTEST))
        |=> zero_flag && !file_we && $stable(w_reg))
        else $error("zero test set wrong");
    chk_ztest_clear: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE8
        (state_q == nstx_pkg::NSTX_IDLE && instr_valid && file_rdata != 8'h00
         && match(instr, nstx_pkg::NSTX_OP_ZTEST_MASK, nstx_pkg::NSTX_OP_ZTEST))
        |=> !zero_flag)
        else $error("zero test clear wrong");
    chk_xor_lit: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE6
        (state_q == nstx_pkg::NSTX_IDLE && instr_valid
         && match(instr, nstx_pkg::NSTX_OP_SWAP_MASK, nstx_pkg::NSTX_OP_XORL))
        |=> w_reg == ($past(w_reg) ^ $past(instr[7:0])) && zero_flag == (w_reg == 8'h00))
        else $error("xor literal wrong");
    chk_xor_file: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE7
        (state_q == nstx_pkg::NSTX_IDLE && instr_valid && dest_file
         && match(instr, nstx_pkg::NSTX_OP_SWAP_MASK, nstx_pkg::NSTX_OP_XORF))
        |=> file_we && file_wdata == $past(xored) && zero_flag == (file_wdata == 8'h00))
        else $error("xor file wrong");
    chk_xor_to_w: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE7
        (state_q == nstx_pkg::NSTX_IDLE && instr_valid && !dest_file
         && match(instr, nstx_pkg::NSTX_OP_SWAP_MASK, nstx_pkg::NSTX_OP_XORF))
        |=> w_reg == $past(xored) && !file_we && zero_flag == (w_reg == 8'h00))
        else $error("xor file to w wrong");
    chk_xorl_no_write: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE6
        (state_q == nstx_pkg::NSTX_IDLE && instr_valid
         && match(instr, nstx_pkg::NSTX_OP_SWAP_MASK, nstx_pkg::NSTX_OP_XORL))
        |=> !file_we && $stable(file_wdata))
        else $error("xor literal touched file");
    // fetch strobes last exactly one cycle
    chk_fetch_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE2
        (state_q == nstx_pkg::NSTX_TAB_FETCH)
        |-> busy && rom_re ##1 (!busy && !rom_re))
        else $error("fetch strobe wrong");
    // an instruction offered during the fetch is dropped, not queued
    chk_fetch_ignore: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE3
        (state_q == nstx_pkg::NSTX_TAB_FETCH && instr_valid)
        |=> !file_we && $stable(zero_flag) && !busy)
        else $error("instruction taken while busy");
    chk_tab_low_flags: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE3
        tab_start(1'b0) |=> $stable(zero_flag) && !file_we
        ##1 $stable(zero_flag) && !file_we)
        else $error("table low read touched flags");
    chk_tab_high_write: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE2
        tab_start(1'b1) |=> !file_we
        ##1 !file_we)
        else $error("table high read wrote file");
    chk_ztest_no_write: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE8
        (state_q == nstx_pkg::NSTX_IDLE && instr_valid && file_rdata != 8'h00
         && match(instr, nstx_pkg::NSTX_OP_ZTEST_MASK, nstx_pkg::NSTX_OP_ZTEST))
        |=> !file_we && $stable(w_reg))
        else $error("zero test clear wrote data");
    // pointer must not move while the rom word is being read
    chk_pointer_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE4
        (state_q == nstx_pkg::NSTX_TAB_FETCH)
        |=> $stable(table_pointer))
        else $error("table pointer moved in fetch");
endmodule

/* File: design/nstx_pkg.sv */
package nstx_pkg;
    // opcode patterns, 14 bits
    localparam logic [13:0] NSTX_OP_SWAP_MASK  = 14'h3f00;
    localparam logic [13:0] NSTX_OP_SWAP       = 14'h0e00;
    localparam logic [13:0] NSTX_OP_XORF       = 14'h0600;
    localparam logic [13:0] NSTX_OP_ZTEST_MASK = 14'h3f80;
    localparam logic [13:0] NSTX_OP_ZTEST      = 14'h0880;
    localparam logic [13:0] NSTX_OP_XORL       = 14'h1f00;
    localparam logic [13:0] NSTX_OP_TABH       = 14'h0058;
    localparam logic [13:0] NSTX_OP_TABL       = 14'h0050;
    localparam int          NSTX_DEST_BIT      = 7;
    localparam int          NSTX_ADDR_W        = 7;
    localparam int          NSTX_PC_W          = 12;
    localparam int          NSTX_PAGE_W        = NSTX_PC_W - 8;
    localparam logic [7:0]  NSTX_W_RESET       = 8'h00;
    typedef enum logic [1:0] {NSTX_IDLE, NSTX_TAB_FETCH} nstx_state_t;
endpackage

/* File: bench/nstx_mem.sv */
`timescale 1ns/1ns
module nstx_mem (
    input  wire logic                             ref_clk,
    input  wire logic [nstx_pkg::NSTX_ADDR_W-1:0] file_addr,
    input  wire logic                             file_we,
    input  wire logic [7:0]                       file_wdata,
    input  wire logic [nstx_pkg::NSTX_PC_W-1:0]   table_pointer,
    input  wire logic                             rom_re,
    output logic [7:0]                            file_rdata,
    output logic [13:0]                           rom_rdata
);
    logic [7:0]                       regs [0:127];
    logic [nstx_pkg::NSTX_ADDR_W-1:0] addr_q;
    logic [13:0]                      word;
    // word depends on the pointer, so a wrong pointer shows up in w
    assign word = 14'h3789 ^ {2'h0, table_pointer};
    assign file_rdata = regs[file_addr];
    // inverted outside the fetch cycle so stale data never passes
    assign rom_rdata = rom_re ? word : ~word;
    always @(posedge ref_clk) begin
        addr_q <= file_addr;
        if (file_we) begin
            regs[addr_q] <= file_wdata;
        end
    end
endmodule

/* File: bench/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
    logic ref_clk = 0, rst_n = 0, instr_valid = 0, busy, file_we, rom_re, zero_flag, z, b1;
    logic [13:0] instr = 14'h0000, rom_rdata;
    logic [7:0] file_rdata, file_wdata, w_reg, ind = 8'h00;
    logic [3:0] page = 4'h0;
    logic [6:0] file_addr;
    logic [11:0] table_pointer;
    int miscompares = 0, checks = 0;
    nstx_exec dut (.ref_clk(ref_clk), .rst_n(rst_n), .instr_valid(instr_valid),
        .instr(instr), .file_rdata(file_rdata), .table_page_register(page),
        .indirect_address_register(ind), .rom_rdata(rom_rdata), .busy(busy),
        .file_addr(file_addr), .file_we(file_we), .file_wdata(file_wdata),
        .table_pointer(table_pointer), .rom_re(rom_re), .w_reg(w_reg), .zero_flag(zero_flag));
    nstx_mem mem (.ref_clk(ref_clk), .file_addr(file_addr), .file_we(file_we),
        .file_wdata(file_wdata), .table_pointer(table_pointer), .rom_re(rom_re),
        .file_rdata(file_rdata), .rom_rdata(rom_rdata));
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    task chk(input string name, input logic [13:0] exp, input logic [13:0] got);
        checks++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            miscompares++;
        end
    endtask
    task issue(input logic [13:0] op);
        @(posedge ref_clk);
        instr_valid <= 1'b1;
        instr <= op;
        @(posedge ref_clk);
        instr_valid <= 1'b0;
        #1 b1 = busy & rom_re;
        @(posedge ref_clk);
        #1;
    endtask
    task t_swap;
        mem.regs[5] = 8'ha5;
        z = zero_flag;
        issue(14'h0e05);
        chk("swap w", 14'h005a, {6'h0, w_reg});
        chk("swap z", {13'h0, z}, {13'h0, zero_flag});
        issue(14'h0e85);
        chk("swap f", 14'h005a, {6'h0, mem.regs[5]});
        $display("test swap done");
    endtask
    task t_xor;
        issue(14'h1f5a);
        chk("xorl zero", 14'h0100, {5'h0, zero_flag, w_reg});
        issue(14'h1faf);
        chk("xorl af", 14'h00af, {5'h0, zero_flag, w_reg});
        mem.regs[9] = 8'haf;
        mem.regs[10] = 8'h1a;
        issue(14'h0689);
        chk("xorf f", 14'h0000, {6'h0, mem.regs[9]});
        chk("xorf f w z", 14'h01af, {5'h0, zero_flag, w_reg});
        issue(14'h060a);
        chk("xorf w", 14'h00b5, {5'h0, zero_flag, w_reg});
        $display("test xor done");
    endtask
    task t_ztest;
        mem.regs[3] = 8'h00;
        mem.regs[4] = 8'h01;
        issue(14'h0883);
        chk("ztest set", 14'h01b5, {5'h0, zero_flag, w_reg});
        chk("ztest keep", 14'h0000, {6'h0, mem.regs[3]});
        issue(14'h0884);
        chk("ztest clear", 14'h00b5, {5'h0, zero_flag, w_reg});
        $display("test ztest done");
    endtask
    task t_tab;
        @(posedge ref_clk);
        page <= 4'h2;
        ind <= 8'h34;
        issue(14'h0050);
        chk("tabl busy", 14'h0001, {13'h0, b1});
        chk("tabl ptr", 14'h0234, {2'h0, table_pointer});
        chk("tabl w", 14'h00bd, {5'h0, zero_flag, w_reg});
        @(posedge ref_clk);
        page <= 4'hf;
        ind <= 8'hff;
        issue(14'h0058);
        chk("tabh busy", 14'h0001, {13'h0, b1});
        chk("tabh ptr", 14'h0fff, {2'h0, table_pointer});
        chk("tabh w", 14'h0038, {5'h0, zero_flag, w_reg});
        $display("test table done");
    endtask
    task finish_test;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_swap;
        t_xor;
        t_ztest;
        t_tab;
        finish_test;
    end
    initial begin
        #20000;
        miscompares++;
        finish_test;
    end
endmodule
